/* File: dual_port_power_state_control.sv */
// Purpose: Power state and switch control for a two-port power switch
// Assumes: Serial engine supplies byte register strobes; analog levels synchronous
// Notes:   Off state is modelled by core_supply_ok low
// Functional notes
// - Each port enable control is its pin ORed with its software bit.
// - Below core supply threshold: no state kept, bus ignored, switches open.
// - Both controls inactive gives Sleep: switches open, buses grounded, state kept.
// - Active closes each enabled channel; disabled channel stays open.
// - Active performs switching and current limiting for enabled channels.
// - A fault puts only its own channel into fault handling.
// - Error state outranks Active when updating power state.
// - Entering fault handling records the fault in that channel's status.
// - Trip mode opens switch once current reaches the limit threshold.
// - Constant current keeps running; opens switch below the bus voltage floor.
// - Auto discharge grounds disabled ports; otherwise host commands discharge.
// - Stand-alone mode disables serial access; only pins remain.
// - First read while asleep wakes device and returns zero.
// - Auto recovery rechecks all faults after the cycle period.
// - Sleep releases and withholds both fault alerts.
`timescale 1ns/10ps
`default_nettype none
`include "power_defines.svh"
module dual_port_power_state_control #(
  parameter logic [`CNT_W-1:0] RECOVERY_CYCLES = `RECOVERY_DFLT,
  parameter logic [`CNT_W-1:0] IDLE_SLEEP_CYCLES = `IDLE_SLEEP_DFLT
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        core_supply_ok,
  // Strap and enable pins
  input  wire logic        standalone_strap,
  input  wire logic        port_one_enable_in,
  input  wire logic        port_two_enable_in,
  // Analog sensing per channel
  input  wire logic [1:0]  current_limit_threshold_reached,
  input  wire logic [1:0]  bus_below_floor,
  input  wire logic [1:0]  other_fault,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  // Port outputs
  output logic [1:0]       switch_close,
  output logic [1:0]       discharge_on,
  output logic             port_one_fault_alert_n,
  output logic             port_two_fault_alert_n,
  output logic [3:0]       power_state
);
  power_pkg::top_regs_t s_ff;
  power_pkg::top_regs_t nxt_s;
  logic [1:0]           en_pin;
  logic                 pol_now;
  logic                 sa_now;
  logic [1:0]           en_ctl;
  logic [1:0]           ch_err;
  logic [1:0]           ch_evt;
  logic [`CODE_W-1:0]   code_one;
  logic [`CODE_W-1:0]   code_two;
  logic [1:0]           cc_sel;
  logic                 bus_ok;
  logic [7:0]           set1;
  logic [7:0]           set2;
  logic [7:0]           clr1;
  logic [7:0]           clr2;

  // Effective enable controls
  always_comb
  begin
    // Live strap on the capture edge, so pin polarity never glitches a switch
    sa_now = s_ff.strap_done ? s_ff.standalone : standalone_strap;
    pol_now = s_ff.strap_done ? s_ff.pol_low : standalone_strap;
    en_pin = {port_two_enable_in, port_one_enable_in} ^ {2{pol_now}};
    en_ctl[0] = en_pin[0] | (s_ff.cfg1[`CFG1_SW_EN] & !sa_now);
    en_ctl[1] = en_pin[1] | (s_ff.cfg2[`CFG2_SW_EN] & !sa_now);
    cc_sel = {s_ff.cfg1[`CFG1_CC_TWO], s_ff.cfg1[`CFG1_CC_ONE]};
  end

  // Channel one
  port_channel_ctrl #(
    .RECOVERY_CYCLES (RECOVERY_CYCLES)
  ) u_ch_one (
    .clk             (clk),
    .rst_b           (rst_b),
    .clear           (!core_supply_ok),
    .enable_ctl      (en_ctl[0]),
    .cc_mode         (cc_sel[0]),
    .auto_recovery   (s_ff.cfg1[`CFG1_AUTO_REC]),
    .current_limit_threshold_reached    (current_limit_threshold_reached[0]),
    .bus_below_floor (bus_below_floor[0]),
    .other_fault     (other_fault[0]),
    .switch_close    (switch_close[0]),
    .in_error        (ch_err[0]),
    .fault_evt       (ch_evt[0]),
    .fault_code      (code_one)
  );

  // Channel two
  port_channel_ctrl #(
    .RECOVERY_CYCLES (RECOVERY_CYCLES)
  ) u_ch_two (
    .clk             (clk),
    .rst_b           (rst_b),
    .clear           (!core_supply_ok),
    .enable_ctl      (en_ctl[1]),
    .cc_mode         (cc_sel[1]),
    .auto_recovery   (s_ff.cfg1[`CFG1_AUTO_REC]),
    .current_limit_threshold_reached    (current_limit_threshold_reached[1]),
    .bus_below_floor (bus_below_floor[1]),
    .other_fault     (other_fault[1]),
    .switch_close    (switch_close[1]),
    .in_error        (ch_err[1]),
    .fault_evt       (ch_evt[1]),
    .fault_code      (code_two)
  );

  // Next state of registers, power state and outputs
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.rvalid = 1'b0;
    set1 = `REG_RESET;
    set2 = `REG_RESET;
    clr1 = `REG_RESET;
    clr2 = `REG_RESET;
    // Strap caught once after reset release
    if (!s_ff.strap_done)
    begin
      nxt_s.strap_done = 1'b1;
      nxt_s.standalone = standalone_strap;
      nxt_s.pol_low = standalone_strap;
    end
    // Power state, error first
    if (|ch_err)
      nxt_s.st = power_pkg::DEV_ERROR;
    else if (!en_ctl[0] && !en_ctl[1])
      nxt_s.st = power_pkg::DEV_SLEEP;
    else
      nxt_s.st = power_pkg::DEV_ACTIVE;
    // Serial access gating
    bus_ok = !s_ff.standalone && s_ff.strap_done;
    if (s_ff.st != power_pkg::DEV_SLEEP)
      nxt_s.awake = 1'b0;
    else if (s_ff.awake && (reg_rd || reg_wr))
      nxt_s.idle_cnt = `CNT_ZERO;
    else if (s_ff.awake && (s_ff.idle_cnt >= IDLE_SLEEP_CYCLES - `CNT_ONE))
      nxt_s.awake = 1'b0;
    else if (s_ff.awake)
      nxt_s.idle_cnt = s_ff.idle_cnt + `CNT_ONE;
    // Register reads
    if (reg_rd && bus_ok)
    begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = `REG_RESET;
      if ((s_ff.st == power_pkg::DEV_SLEEP) && !s_ff.awake)
      begin
        nxt_s.awake = 1'b1;
        nxt_s.idle_cnt = `CNT_ZERO;
      end
      else
        case (reg_addr)
          `REG_STAT_ONE: nxt_s.rdata = s_ff.stat1;
          `REG_STAT_TWO: nxt_s.rdata = s_ff.stat2;
          `REG_STATE:    nxt_s.rdata = {4'h0, s_ff.st};
          `REG_CFG_ONE:  nxt_s.rdata = s_ff.cfg1;
          `REG_CFG_TWO:  nxt_s.rdata = s_ff.cfg2;
          default:       nxt_s.rdata = `REG_RESET;
        endcase
    end
    // Register writes, ignored while asleep and not yet woken
    if (reg_wr && bus_ok && ((s_ff.st != power_pkg::DEV_SLEEP) || s_ff.awake))
      case (reg_addr)
        `REG_STAT_ONE: clr1 = reg_wdata;
        `REG_STAT_TWO: clr2 = reg_wdata;
        `REG_CFG_ONE:  nxt_s.cfg1 = reg_wdata;
        `REG_CFG_TWO:  nxt_s.cfg2 = reg_wdata;
        default:       nxt_s.cfg1 = s_ff.cfg1;
      endcase
    // Fault recording, set wins over clear
    if (ch_evt[0])
      set1[`CODE_W-1:0] = code_one;
    if (ch_evt[1])
      set2[`CODE_W-1:0] = code_two;
    nxt_s.stat1 = (s_ff.stat1 & ~clr1) | set1;
    nxt_s.stat2 = (s_ff.stat2 & ~clr2) | set2;
    // Alerts low per faulted channel, never in Sleep
    nxt_s.alert_n = ~ch_err | {2{nxt_s.st == power_pkg::DEV_SLEEP}};
    // Discharge of open ports
    if (nxt_s.st == power_pkg::DEV_SLEEP)
      nxt_s.dis = 2'b11;
    else if (s_ff.cfg2[`CFG2_AUTO_DIS])
      nxt_s.dis = ~en_ctl | ch_err;
    else
      nxt_s.dis = {s_ff.cfg2[`CFG2_MAN_DIS_TWO], s_ff.cfg2[`CFG2_MAN_DIS_ONE]};
    // Reset and Off drop all state
    if (!rst_b || !core_supply_ok)
    begin
      nxt_s.st = power_pkg::DEV_OFF;
      nxt_s.strap_done = 1'b0;
      nxt_s.standalone = 1'b0;
      nxt_s.pol_low = 1'b0;
      nxt_s.cfg1 = `REG_RESET;
      nxt_s.cfg2 = `REG_RESET;
      nxt_s.stat1 = `REG_RESET;
      nxt_s.stat2 = `REG_RESET;
      nxt_s.awake = 1'b0;
      nxt_s.idle_cnt = `CNT_ZERO;
      nxt_s.rdata = `REG_RESET;
      nxt_s.rvalid = 1'b0;
      nxt_s.alert_n = 2'b11;
      nxt_s.dis = 2'b00;
    end
  end

  // State register
  always_ff @(posedge clk)
    s_ff <= nxt_s;

  // Outputs from flops
  assign reg_rdata              = s_ff.rdata;
  assign reg_rvalid             = s_ff.rvalid;
  assign discharge_on           = s_ff.dis;
  assign port_one_fault_alert_n = s_ff.alert_n[0];
  assign port_two_fault_alert_n = s_ff.alert_n[1];
  assign power_state            = s_ff.st;

  // Checks
  property p_enable_or;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      $rose(switch_close[0]) |-> $past(en_pin[0] || (s_ff.cfg1[`CFG1_SW_EN] && !s_ff.standalone));
  endproperty
  a_enable_or: assert property (p_enable_or) else $error("switch closed without enable");
  property p_off_open;
    @(posedge clk) disable iff (!rst_b)
      !core_supply_ok |=> (switch_close == 2'b00 && power_state == power_pkg::DEV_OFF && s_ff.cfg1 == `REG_RESET);
  endproperty
  a_off_open: assert property (p_off_open) else $error("off state kept switch or state");
  property p_sleep_quiet;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      (power_state == power_pkg::DEV_SLEEP) |-> (switch_close == 2'b00 && discharge_on == 2'b11);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep with switch closed");
  property p_error_first;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      (|ch_err) |=> (power_state == power_pkg::DEV_ERROR);
  endproperty
  a_error_first: assert property (p_error_first) else $error("error not given precedence");
  property p_fault_logged;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      ch_evt[0] |=> ((s_ff.stat1[`CODE_W-1:0] & $past(code_one)) == $past(code_one));
  endproperty
  a_fault_logged: assert property (p_fault_logged) else $error("fault not recorded");
  property p_alert_sleep;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      (power_state == power_pkg::DEV_SLEEP) |-> (port_one_fault_alert_n && port_two_fault_alert_n);
  endproperty
  a_alert_sleep: assert property (p_alert_sleep) else $error("alert asserted in sleep");
  property p_standalone_lock;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      (s_ff.standalone && reg_wr) |=> ($stable(s_ff.cfg1) && $stable(s_ff.cfg2) && !reg_rvalid);
  endproperty
  a_standalone_lock: assert property (p_standalone_lock) else $error("serial access in stand-alone");
  property p_dummy_read;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      (reg_rd && bus_ok && power_state == power_pkg::DEV_SLEEP && !s_ff.awake) |=> (reg_rvalid && reg_rdata == `REG_RESET);
  endproperty
  a_dummy_read: assert property (p_dummy_read) else $error("dummy read not zero");
  property p_auto_dis;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      (s_ff.cfg2[`CFG2_AUTO_DIS] && !en_ctl[0] && !ch_err[0] && en_ctl[1]) |=> discharge_on[0];
  endproperty
  a_auto_dis: assert property (p_auto_dis) else $error("disabled port not discharged");
  property p_sw_reset_zero;
    @(posedge clk) disable iff (!core_supply_ok)
      $rose(rst_b) |-> (!s_ff.cfg1[`CFG1_SW_EN] && !s_ff.cfg2[`CFG2_SW_EN]);
  endproperty
  a_sw_reset_zero: assert property (p_sw_reset_zero) else $error("software enable not cleared by reset");
  property p_standalone_read;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      (s_ff.standalone && reg_rd) |=> !reg_rvalid;
  endproperty
  a_standalone_read: assert property (p_standalone_read) else $error("read answered in stand-alone");
  property p_idle_open;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      !$past(en_ctl[1]) |-> !switch_close[1];
  endproperty
  a_idle_open: assert property (p_idle_open) else $error("disabled channel switch closed");
  property p_manual_dis;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      !s_ff.cfg2[`CFG2_AUTO_DIS] |=> ((power_state == power_pkg::DEV_SLEEP)
        || (discharge_on == $past({s_ff.cfg2[`CFG2_MAN_DIS_TWO], s_ff.cfg2[`CFG2_MAN_DIS_ONE]})));
  endproperty
  a_manual_dis: assert property (p_manual_dis) else $error("manual discharge not followed");
  property p_asleep_write;
    @(posedge clk) disable iff (!rst_b || !core_supply_ok)
      (reg_wr && power_state == power_pkg::DEV_SLEEP && !s_ff.awake)
        |=> ($stable(s_ff.cfg1) && $stable(s_ff.cfg2));
  endproperty
  a_asleep_write: assert property (p_asleep_write) else $error("write landed before wake");
  c_trip: cover property (@(posedge clk) disable iff (!rst_b) ch_evt[0] ##1 !port_one_fault_alert_n);
  c_wake: cover property (@(posedge clk) disable iff (!rst_b) s_ff.awake ##1 reg_rvalid);
  c_both_on: cover property (@(posedge clk) disable iff (!rst_b) switch_close == 2'b11);
endmodule // dual_port_power_state_control
`default_nettype wire

/* File: power_defines.svh */
// Purpose: Named offsets, field positions, reset values and counts
// Assumes: Byte-wide register port from the serial engine
// Notes:   Included by the package and by both modules
`ifndef POWER_DEFINES_SVH
`define POWER_DEFINES_SVH
// Register map
`define REG_STAT_ONE      8'h00
`define REG_STAT_TWO      8'h01
`define REG_STATE         8'h02
`define REG_CFG_ONE       8'h11
`define REG_CFG_TWO       8'h12
// General configuration one fields
`define CFG1_SW_EN        0
`define CFG1_CC_ONE       1
`define CFG1_CC_TWO       2
`define CFG1_AUTO_REC     3
// General configuration two fields
`define CFG2_SW_EN        0
`define CFG2_AUTO_DIS     1
`define CFG2_MAN_DIS_ONE  2
`define CFG2_MAN_DIS_TWO  3
// Fault status fields
`define FLT_TRIP          0
`define FLT_FLOOR         1
`define FLT_OTHER         2
// Widths and reset values
`define CNT_W             16
`define CODE_W            3
`define REG_RESET         8'h00
`define CODE_NONE         3'h0
`define CNT_ZERO          16'h0000
`define CNT_ONE           16'h0001
`define RECOVERY_DFLT     16'h0040
`define IDLE_SLEEP_DFLT   16'h0080
`endif

/* File: power_pkg.sv */
// Purpose: Shared state types for the power state control
// Assumes: power_defines.svh holds the counter and fault code widths
// Notes:   One-hot state codes
`include "power_defines.svh"
package power_pkg;
  typedef enum logic [3:0] {
    DEV_OFF    = 4'b0001,
    DEV_SLEEP  = 4'b0010,
    DEV_ACTIVE = 4'b0100,
    DEV_ERROR  = 4'b1000
  } dev_state_t;
  typedef enum logic [2:0] {
    CH_IDLE   = 3'b001,
    CH_ACTIVE = 3'b010,
    CH_ERROR  = 3'b100
  } ch_state_t;
  typedef struct packed {
    ch_state_t               st;
    logic [`CNT_W-1:0]       cnt;
    logic                    sw;
    logic                    evt;
    logic [`CODE_W-1:0]      code;
  } ch_regs_t;
  typedef struct packed {
    dev_state_t              st;
    logic                    strap_done;
    logic                    standalone;
    logic                    pol_low;
    logic [7:0]              cfg1;
    logic [7:0]              cfg2;
    logic [7:0]              stat1;
    logic [7:0]              stat2;
    logic                    awake;
    logic [`CNT_W-1:0]       idle_cnt;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic [1:0]              alert_n;
    logic [1:0]              dis;
  } top_regs_t;
endpackage

/* File: port_channel_ctrl.sv */
// Purpose: One port channel: switch control, limiting and fault handling
// Assumes: Analog comparators arrive as synchronous levels
// Notes:   Switch output is a flop that follows the channel state
`timescale 1ns/10ps
`default_nettype none
`include "power_defines.svh"
module port_channel_ctrl #(
  parameter logic [`CNT_W-1:0] RECOVERY_CYCLES = `RECOVERY_DFLT
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                clear,
  // Control
  input  wire logic                enable_ctl,
  input  wire logic                cc_mode,
  input  wire logic                auto_recovery,
  // Sensing
  input  wire logic                current_limit_threshold_reached,
  input  wire logic                bus_below_floor,
  input  wire logic                other_fault,
  // Results
  output logic                     switch_close,
  output logic                     in_error,
  output logic                     fault_evt,
  output logic [`CODE_W-1:0]       fault_code
);
  power_pkg::ch_regs_t s_ff;
  power_pkg::ch_regs_t nxt_s;
  logic [`CODE_W-1:0]  flt;

  // Fault vector per limiting mode
  always_comb
  begin
    flt = `CODE_NONE;
    flt[`FLT_TRIP]  = !cc_mode && current_limit_threshold_reached;
    flt[`FLT_FLOOR] = cc_mode && bus_below_floor;
    flt[`FLT_OTHER] = other_fault;
    nxt_s = s_ff;
    nxt_s.evt = 1'b0;
    nxt_s.code = `CODE_NONE;
    case (s_ff.st)
      power_pkg::CH_IDLE:
        if (enable_ctl && (|flt))
        begin
          nxt_s.st = power_pkg::CH_ERROR;
          nxt_s.evt = 1'b1;
          nxt_s.code = flt;
          nxt_s.cnt = `CNT_ZERO;
        end
        else if (enable_ctl)
          nxt_s.st = power_pkg::CH_ACTIVE;
      power_pkg::CH_ACTIVE:
        if (|flt)
        begin
          nxt_s.st = power_pkg::CH_ERROR;
          nxt_s.evt = 1'b1;
          nxt_s.code = flt;
          nxt_s.cnt = `CNT_ZERO;
        end
        else if (!enable_ctl)
          nxt_s.st = power_pkg::CH_IDLE;
      power_pkg::CH_ERROR:
        if (auto_recovery)
        begin
          if (s_ff.cnt >= RECOVERY_CYCLES - `CNT_ONE)
          begin
            nxt_s.cnt = `CNT_ZERO;
            if (!(current_limit_threshold_reached || bus_below_floor || other_fault))
              nxt_s.st = enable_ctl ? power_pkg::CH_ACTIVE : power_pkg::CH_IDLE;
          end
          else
            nxt_s.cnt = s_ff.cnt + `CNT_ONE;
        end
        else if (!enable_ctl)
          nxt_s.st = power_pkg::CH_IDLE;
      default:
        nxt_s.st = power_pkg::CH_IDLE;
    endcase
    nxt_s.sw = (nxt_s.st == power_pkg::CH_ACTIVE);
    if (!rst_b || clear)
    begin
      nxt_s.st = power_pkg::CH_IDLE;
      nxt_s.cnt = `CNT_ZERO;
      nxt_s.sw = 1'b0;
      nxt_s.evt = 1'b0;
      nxt_s.code = `CODE_NONE;
    end
  end

  // State register
  always_ff @(posedge clk)
    s_ff <= nxt_s;

  assign switch_close = s_ff.sw;
  assign in_error     = (s_ff.st == power_pkg::CH_ERROR);
  assign fault_evt    = s_ff.evt;
  assign fault_code   = s_ff.code;

  // Checks
  property p_trip_opens;
    @(posedge clk) disable iff (!rst_b || clear)
      (switch_close && !cc_mode && current_limit_threshold_reached) |=> (!switch_close && in_error && fault_code[`FLT_TRIP]);
  endproperty
  a_trip_opens: assert property (p_trip_opens) else $error("trip did not open switch");
  property p_cc_keeps;
    @(posedge clk) disable iff (!rst_b || clear)
      (switch_close && cc_mode && current_limit_threshold_reached && !bus_below_floor && !other_fault && enable_ctl) |=> switch_close;
  endproperty
  a_cc_keeps: assert property (p_cc_keeps) else $error("constant current dropped switch");
  property p_floor_opens;
    @(posedge clk) disable iff (!rst_b || clear)
      (switch_close && cc_mode && bus_below_floor) |=> (!switch_close ##1 !switch_close);
  endproperty
  a_floor_opens: assert property (p_floor_opens) else $error("floor did not open switch");
  property p_recover_clean;
    @(posedge clk) disable iff (!rst_b || clear)
      (in_error && auto_recovery ##1 !in_error) |-> $past(!(current_limit_threshold_reached || bus_below_floor || other_fault));
  endproperty
  a_recover_clean: assert property (p_recover_clean) else $error("recovered with fault present");
  c_recovery: cover property (@(posedge clk) disable iff (!rst_b) in_error ##1 !in_error ##1 switch_close);
endmodule // port_channel_ctrl
`default_nettype wire

/* File: attached_port_model.sv */
// Purpose: Attached portable devices on both ports
// Assumes: Current and sag only show while a switch is closed
// Notes:   Overload and sag are commanded by the bench
`timescale 1ns/10ps
`default_nettype none
module attached_port_model (
  // Port state
  input  wire logic [1:0] switch_close,
  // Bench commands
  input  wire logic [1:0] overload,
  input  wire logic [1:0] sag,
  // Sense levels
  output logic      [1:0] current_limit_threshold_reached,
  output logic      [1:0] bus_below_floor
);
  // Load draws current only through a closed switch
  assign current_limit_threshold_reached    = overload & switch_close;
  // Heavy load drags the bus below the floor the same way
  assign bus_below_floor = sag & switch_close;
endmodule // attached_port_model
`default_nettype wire

/* File: dual_port_power_state_control_tb.sv */
// Purpose: Self-checking bench for the power state control
// Assumes: Short recovery and idle counts via parameters
// Notes:   Register port driven by hand-written tasks
`timescale 1ns/10ps
`default_nettype none
module dual_port_power_state_control_tb;
  localparam logic [15:0] REC = 16'h0004;
  localparam logic [15:0] IDL = 16'h0008;
  logic       clk, rst_b, core_supply_ok, standalone_strap;
  logic       port_one_enable_in, port_two_enable_in;
  logic [1:0] current_limit_threshold_reached, bus_below_floor, other_fault, overload, sag;
  logic       reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] switch_close, discharge_on;
  logic       port_one_fault_alert_n, port_two_fault_alert_n;
  logic [3:0] power_state;
  int         miscompares, samples_checked;

  // Device under test
  dual_port_power_state_control #(.RECOVERY_CYCLES(REC), .IDLE_SLEEP_CYCLES(IDL)) u_dut (
    .clk(clk), .rst_b(rst_b), .core_supply_ok(core_supply_ok), .standalone_strap(standalone_strap),
    .port_one_enable_in(port_one_enable_in), .port_two_enable_in(port_two_enable_in),
    .current_limit_threshold_reached(current_limit_threshold_reached), .bus_below_floor(bus_below_floor), .other_fault(other_fault),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .switch_close(switch_close),
    .discharge_on(discharge_on), .port_one_fault_alert_n(port_one_fault_alert_n),
    .port_two_fault_alert_n(port_two_fault_alert_n), .power_state(power_state));

  // Attached devices on the ports
  attached_port_model u_load (.switch_close(switch_close), .overload(overload), .sag(sag),
    .current_limit_threshold_reached(current_limit_threshold_reached), .bus_below_floor(bus_below_floor));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Power state, switches and alerts together
  task automatic st(input logic [3:0] s, input logic [1:0] sw, input logic [1:0] al);
    chk("power_state", {4'h0, s}, {4'h0, power_state});
    chk("switch_close", {6'h00, sw}, {6'h00, switch_close});
    chk("alerts", {6'h00, al}, {6'h00, port_two_fault_alert_n, port_one_fault_alert_n});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    tick(2);
  endtask

  // Read answers exactly one cycle after the request edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic vexp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk("reg_rvalid", {7'h00, vexp}, {7'h00, reg_rvalid});
    if (vexp)
      chk("reg_rdata", exp, reg_rdata);
  endtask

  task automatic do_reset(input logic strap);
    @(posedge clk);
    rst_b            <= 1'b0;
    standalone_strap <= strap;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    tick(3);
  endtask

  // Reset values, dummy wake read, software enable
  task automatic t_reset_wake;
    st(4'h2, 2'h0, 2'h3);
    chk("discharge", 8'h03, {6'h00, discharge_on});
    rd(8'h11, 8'h00, 1'b1);
    wr(8'h11, 8'h01);
    rd(8'h11, 8'h01, 1'b1);
    st(4'h4, 2'h1, 2'h3);
    @(posedge clk);
    port_two_enable_in <= 1'b1;
    tick(3);
    st(4'h4, 2'h3, 2'h3);
    rd(8'h40, 8'h00, 1'b1);
  endtask

  // Trip fault on port one only
  task automatic t_trip;
    @(posedge clk);
    overload <= 2'h1;
    tick(4);
    st(4'h8, 2'h2, 2'h2);
    rd(8'h02, 8'h08, 1'b1);
    rd(8'h00, 8'h01, 1'b1);
    rd(8'h01, 8'h00, 1'b1);
    @(posedge clk);
    overload <= 2'h0;
    wr(8'h11, 8'h00);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h00, 1'b1);
    st(4'h4, 2'h2, 2'h3);
  endtask

  // Constant current: overload tolerated, floor opens switch
  task automatic t_cc;
    wr(8'h11, 8'h03);
    @(posedge clk);
    overload <= 2'h1;
    tick(4);
    st(4'h4, 2'h3, 2'h3);
    @(posedge clk);
    sag <= 2'h1;
    tick(4);
    st(4'h8, 2'h2, 2'h2);
    rd(8'h00, 8'h02, 1'b1);
    @(posedge clk);
    overload <= 2'h0;
    sag      <= 2'h0;
    wr(8'h11, 8'h00);
    wr(8'h00, 8'h07);
  endtask

  // Auto recovery waits for other_fault on port one to clear
  task automatic t_recovery;
    wr(8'h11, 8'h09);
    @(posedge clk);
    other_fault <= 2'h1;
    tick(3);
    st(4'h8, 2'h2, 2'h2);
    tick(3 * REC + 2);
    st(4'h8, 2'h2, 2'h2);
    @(posedge clk);
    other_fault <= 2'h0;
    tick(2 * REC + 4);
    st(4'h4, 2'h3, 2'h3);
    wr(8'h11, 8'h00);
    wr(8'h00, 8'h07);
  endtask

  // Automatic discharge of the idle port, host-commanded discharge of port two
  task automatic t_discharge;
    wr(8'h12, 8'h02);
    chk("discharge", 8'h01, {6'h00, discharge_on});
    wr(8'h12, 8'h08);
    chk("discharge", 8'h02, {6'h00, discharge_on});
    wr(8'h12, 8'h00);
    chk("discharge", 8'h00, {6'h00, discharge_on});
    wr(8'h12, 8'h02);
  endtask

  // Alert released on the way into sleep
  task automatic t_sleep;
    @(posedge clk);
    other_fault <= 2'h2;
    tick(4);
    st(4'h8, 2'h0, 2'h1);
    @(posedge clk);
    other_fault        <= 2'h0;
    port_two_enable_in <= 1'b0;
    tick(4);
    st(4'h2, 2'h0, 2'h3);
    chk("discharge", 8'h03, {6'h00, discharge_on});
    tick(2 * IDL);
    wr(8'h12, 8'h01);
    rd(8'h12, 8'h00, 1'b1);
    rd(8'h12, 8'h02, 1'b1);
  endtask

  // Supply loss forgets everything and opens switches
  task automatic t_off;
    @(posedge clk);
    port_one_enable_in <= 1'b1;
    core_supply_ok     <= 1'b0;
    tick(3);
    st(4'h1, 2'h0, 2'h3);
    rd(8'h11, 8'h00, 1'b0);
    @(posedge clk);
    core_supply_ok     <= 1'b0;
    port_one_enable_in <= 1'b0;
    @(posedge clk);
    core_supply_ok <= 1'b1;
    tick(3);
    rd(8'h12, 8'h00, 1'b1);
    rd(8'h12, 8'h00, 1'b1);
  endtask

  // Stand-alone: pins active low, serial access dead
  task automatic t_standalone;
    @(posedge clk);
    port_one_enable_in <= 1'b1;
    port_two_enable_in <= 1'b1;
    do_reset(1'b1);
    st(4'h2, 2'h0, 2'h3);
    @(posedge clk);
    port_one_enable_in <= 1'b0;
    tick(3);
    st(4'h4, 2'h1, 2'h3);
    wr(8'h11, 8'h01);
    rd(8'h11, 8'h00, 1'b0);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #(100 * 20000);
    miscompares++;
    close_out();
  end

  // Main sequence
  initial
  begin
    miscompares = 0;
    samples_checked = 0;
    rst_b <= 1'b0;
    core_supply_ok <= 1'b1;
    standalone_strap <= 1'b0;
    port_one_enable_in <= 1'b0;
    port_two_enable_in <= 1'b0;
    other_fault <= 2'h0;
    overload <= 2'h0;
    sag <= 2'h0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= 8'h00;
    reg_wdata <= 8'h00;
    do_reset(1'b0);
    t_reset_wake();
    t_trip();
    t_cc();
    t_recovery();
    t_discharge();
    t_sleep();
    t_off();
    t_standalone();
    close_out();
  end
endmodule // dual_port_power_state_control_tb
`default_nettype wire
